// File: verilog/ccs_pkg.sv
package ccs_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  // Printed offsets 0x6a and 0x6b are not word aligned, so every printed offset is an index.
  localparam logic [7:0] CCS_IDX_CORE_PARK  = 8'h64;
  localparam logic [7:0] CCS_IDX_AVERAGING  = 8'h68;
  localparam logic [7:0] CCS_IDX_STATUS     = 8'h6a;
  localparam logic [7:0] CCS_IDX_PIN_SETUP  = 8'h6b;
  localparam logic [7:0] CCS_IDX_CAL_CFG    = 8'h80;
  localparam logic [7:0] CCS_IDX_SOFT_TRIG  = 8'h81;
  localparam logic [7:0] CCS_IDX_ROUTING    = 8'h82;

  localparam logic [7:0] CCS_RST_CORE_PARK  = 8'h02;
  localparam logic [7:0] CCS_RST_AVERAGING  = 8'h61;
  localparam logic [7:0] CCS_RST_PIN_SETUP  = 8'h00;
  localparam logic [7:0] CCS_RST_CAL_CFG    = 8'h00;
  localparam logic [7:0] CCS_RST_SOFT_TRIG  = 8'h01;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CCS_PARK_LSB      = 0;
  localparam int CCS_OFFSET_AVG_LSB = 4;
  localparam int CCS_LIN_AVG_LSB   = 0;
  localparam int CCS_STAT_CODE_LSB = 2;
  localparam int CCS_STOPPED_BIT   = 1;
  localparam int CCS_FG_COMPLETE_BIT = 0;
  localparam int CCS_STAT_SEL_LSB  = 1;
  localparam int CCS_TRIG_SRC_BIT  = 0;
  localparam int CCS_BG_EN_BIT     = 1;
  localparam int CCS_SOFT_TRIG_BIT = 0;

  localparam logic [1:0] CCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CCS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CCS_SEL_FG_COMPLETE = 2'h0,
    CCS_SEL_STOPPED = 2'h1,
    CCS_SEL_ALARM   = 2'h2,
    CCS_SEL_LOW     = 2'h3
  } ccs_stat_sel_t;

  typedef struct packed {
    logic [7:0] core_park;
    logic [7:0] averaging;
    logic [7:0] pin_setup;
    logic [7:0] cal_cfg;
    logic [7:0] soft_trig;
    logic       fg_complete;
    logic       stopped;
    logic [2:0] stat_code;
    logic       trig_s1;
    logic       trig_s2;
    logic       status_pin;
    logic       aw_full;
    logic [7:0] aw_idx;
    logic       w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ccs_state_t;

  // Status reported by the calibration engine.
  typedef struct packed {
    logic       fg_finished;
    logic       bg_halted;
    logic       running;
    logic [2:0] code;
    logic       alarm;
  } ccs_engine_t;

  // Controls handed to the calibration engine.
  typedef struct packed {
    logic       bg_enable;
    logic [1:0] parked_core;
    logic [1:0] stand_in_core;
    logic       stand_in_active;
    logic [2:0] offset_averaging_depth;
    logic [2:0] linearity_averaging_depth;
    logic       trigger;
  } ccs_ctrl_t;

endpackage

// File: verilog/ccs_top.sv
`timescale 1ns/1ps
// What this block does
// - Park field picks off core when background off.
// - Core one stands in for parked core zero/two.
// - Offset averaging depth from bits 6:4, reset 6.
// - Linearity averaging depth from bits 2:0, reset 1.
// - Read-only status: code, stopped, foreground-complete.
// - Stopped set when background calibration halts.
// - Stopped cleared when calibration resumes.
// - Background off: stopped set on foreground end.
// - Foreground-complete held high after finish or skip.
// - Status pin selector: done, stopped, alarm, low.
// - Trigger source 0 uses software bit only.
// - Trigger source 1 uses hardware pin only.
// - Background runs only with its enable set.
// - Software trigger bit resets to one.
module ccs_top (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire logic [9:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [9:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire ccs_pkg::ccs_engine_t engine,
  output ccs_pkg::ccs_ctrl_t       ctrl,
  input  wire logic                trigger_input_pin,
  output logic                     status_output_pin
);

  // ---------------------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------------------
  function automatic logic idx_known(input logic [7:0] idx);
    idx_known = (idx == ccs_pkg::CCS_IDX_CORE_PARK) || (idx == ccs_pkg::CCS_IDX_AVERAGING) ||
                (idx == ccs_pkg::CCS_IDX_STATUS) || (idx == ccs_pkg::CCS_IDX_PIN_SETUP) ||
                (idx == ccs_pkg::CCS_IDX_CAL_CFG) || (idx == ccs_pkg::CCS_IDX_SOFT_TRIG) ||
                (idx == ccs_pkg::CCS_IDX_ROUTING);
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? data[7:0] : old;
  endfunction

  ccs_pkg::ccs_state_t s_q;
  ccs_pkg::ccs_state_t s_d;
  logic                do_write;
  logic                ar_take;
  logic [7:0]          ar_idx;
  logic                trig_sel;
  logic [1:0]          stat_sel;

  assign s_axi_awready = !s_q.aw_full && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_full && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign do_write      = (s_q.aw_full || (s_axi_awvalid && s_axi_awready)) &&
                         (s_q.w_full || (s_axi_wvalid && s_axi_wready));
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[9:2];
  assign trig_sel      = s_q.pin_setup[ccs_pkg::CCS_TRIG_SRC_BIT];
  assign stat_sel      = s_q.pin_setup[ccs_pkg::CCS_STAT_SEL_LSB +: 2];

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [7:0]  widx;
    logic [31:0] wdat;
    logic [3:0]  wstb;
    widx = 8'h00;
    wdat = 32'h0000_0000;
    wstb = 4'h0;
    s_d = s_q;
    s_d.trig_s1 = trigger_input_pin;
    s_d.trig_s2 = s_q.trig_s1;
    // Status flags track the engine; a set wins over any clear in the same cycle.
    s_d.stat_code = engine.code;
    if (engine.fg_finished) begin
      s_d.fg_complete = 1'b1;
    end
    if (s_q.cal_cfg[ccs_pkg::CCS_BG_EN_BIT]) begin
      if (engine.bg_halted) begin
        s_d.stopped = 1'b1;
      end else if (engine.running) begin
        s_d.stopped = 1'b0;
      end
    end else if (engine.fg_finished) begin
      s_d.stopped = 1'b1;
    end else if (engine.running) begin
      s_d.stopped = 1'b0;
    end
    case (stat_sel)
      ccs_pkg::CCS_SEL_FG_COMPLETE: s_d.status_pin = s_q.fg_complete;
      ccs_pkg::CCS_SEL_STOPPED: s_d.status_pin = s_q.stopped;
      ccs_pkg::CCS_SEL_ALARM:   s_d.status_pin = engine.alarm;
      default:                  s_d.status_pin = 1'b0;
    endcase
    // Write channel capture.
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_idx  = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      widx = s_q.aw_full ? s_q.aw_idx : s_axi_awaddr[9:2];
      wdat = s_q.w_full ? s_q.w_data : s_axi_wdata;
      wstb = s_q.w_full ? s_q.w_strb : s_axi_wstrb;
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = idx_known(widx) ? ccs_pkg::CCS_RESP_OKAY : ccs_pkg::CCS_RESP_SLVERR;
      case (widx)
        ccs_pkg::CCS_IDX_CORE_PARK: s_d.core_park = merge_byte(s_q.core_park, wdat, wstb);
        ccs_pkg::CCS_IDX_AVERAGING: s_d.averaging = merge_byte(s_q.averaging, wdat, wstb);
        ccs_pkg::CCS_IDX_PIN_SETUP: s_d.pin_setup = merge_byte(s_q.pin_setup, wdat, wstb);
        ccs_pkg::CCS_IDX_CAL_CFG:   s_d.cal_cfg   = merge_byte(s_q.cal_cfg, wdat, wstb);
        ccs_pkg::CCS_IDX_SOFT_TRIG: s_d.soft_trig = merge_byte(s_q.soft_trig, wdat, wstb);
        default:                    s_d.bresp     = s_d.bresp;
      endcase
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read channel.
    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = idx_known(ar_idx) ? ccs_pkg::CCS_RESP_OKAY : ccs_pkg::CCS_RESP_SLVERR;
      case (ar_idx)
        ccs_pkg::CCS_IDX_CORE_PARK: s_d.rdata = {24'h000000, s_q.core_park};
        ccs_pkg::CCS_IDX_AVERAGING: s_d.rdata = {24'h000000, s_q.averaging};
        ccs_pkg::CCS_IDX_STATUS:    s_d.rdata = {27'h0000000, s_q.stat_code, s_q.stopped, s_q.fg_complete};
        ccs_pkg::CCS_IDX_PIN_SETUP: s_d.rdata = {24'h000000, s_q.pin_setup};
        ccs_pkg::CCS_IDX_CAL_CFG:   s_d.rdata = {24'h000000, s_q.cal_cfg};
        ccs_pkg::CCS_IDX_SOFT_TRIG: s_d.rdata = {24'h000000, s_q.soft_trig};
        ccs_pkg::CCS_IDX_ROUTING:   s_d.rdata = {26'h0000000, ctrl.stand_in_active, ctrl.stand_in_core,
                                                 ctrl.parked_core, ctrl.trigger};
        default:                    s_d.rdata = 32'h0000_0000;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.core_park <= ccs_pkg::CCS_RST_CORE_PARK;
      s_q.averaging <= ccs_pkg::CCS_RST_AVERAGING;
      s_q.pin_setup <= ccs_pkg::CCS_RST_PIN_SETUP;
      s_q.cal_cfg   <= ccs_pkg::CCS_RST_CAL_CFG;
      s_q.soft_trig <= ccs_pkg::CCS_RST_SOFT_TRIG;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Engine controls
  // ---------------------------------------------------------------------------
  always_comb begin
    ctrl                           = '0;
    ctrl.bg_enable                 = s_q.cal_cfg[ccs_pkg::CCS_BG_EN_BIT];
    ctrl.parked_core               = ctrl.bg_enable ? 2'h3 : s_q.core_park[ccs_pkg::CCS_PARK_LSB +: 2];
    ctrl.stand_in_active           = !ctrl.bg_enable &&
                                     (ctrl.parked_core == 2'h0 || ctrl.parked_core == 2'h2);
    ctrl.stand_in_core             = ctrl.stand_in_active ? 2'h1 : 2'h0;
    ctrl.offset_averaging_depth    = s_q.averaging[ccs_pkg::CCS_OFFSET_AVG_LSB +: 3];
    ctrl.linearity_averaging_depth = s_q.averaging[ccs_pkg::CCS_LIN_AVG_LSB +: 3];
    ctrl.trigger                   = trig_sel ? s_q.trig_s2
                                              : s_q.soft_trig[ccs_pkg::CCS_SOFT_TRIG_BIT];
  end

  assign status_output_pin = s_q.status_pin;
  assign s_axi_bvalid      = s_q.bvalid;
  assign s_axi_bresp       = s_q.bresp;
  assign s_axi_rvalid      = s_q.rvalid;
  assign s_axi_rdata       = s_q.rdata;
  assign s_axi_rresp       = s_q.rresp;

endmodule

// File: test/ccs_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host logic at the trigger and status pins
// ---------------------------------------------------------------
module ccs_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic want_trig,
  input  wire logic status_output_pin,
  output logic      trigger_input_pin,
  output logic      status_seen_q
);
  // The host flop moves the pin just after an edge and samples the status pin.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_input_pin <= 1'b1;
      status_seen_q     <= 1'b0;
    end else begin
      trigger_input_pin <= want_trig;
      status_seen_q     <= status_output_pin;
    end
  end
endmodule

// File: test/ccs_assertions.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bus handshake and control output checks
// ---------------------------------------------------------------
module ccs_checker (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               clk_en,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rready,
  input wire ccs_pkg::ccs_ctrl_t ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_STAND_IN: assert property (!ctrl.bg_enable && !ctrl.parked_core[0]
    |-> ctrl.stand_in_active && ctrl.stand_in_core == 2'h1) else $error("stand-in core missing");
  AST_NO_STAND_IN: assert property (!ctrl.stand_in_active |-> ctrl.stand_in_core == 2'h0)
    else $error("stand-in core without a parked core");
  AST_BG_NO_PARK: assert property (ctrl.bg_enable |-> ctrl.parked_core == 2'h3 && !ctrl.stand_in_active)
    else $error("core parked with background on");
  AST_CORE_ONE: assert property (ctrl.parked_core == 2'h1 |-> !ctrl.stand_in_active)
    else $error("stand-in for core one");
  AST_WR_ANSWER: assert property (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_DONE: assert property (clk_en && s_axi_bvalid && s_axi_bready ##1 1'b1 |-> !s_axi_bvalid)
    else $error("write response repeated");
  AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  AST_RD_ANSWER: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind ccs_top ccs_checker chk_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rready(s_axi_rready), .ctrl(ctrl));

// File: test/tb_calibration_control_status.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end
module tb_calibration_control_status;
  logic                 clk = 1'b0, rst_n = 1'b0, want_trig = 1'b1, ce = 1'b1;
  logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                 awready, wready, bvalid, arready, rvalid, trig_pin, stat_pin, stat_seen;
  logic [9:0]           awaddr = '0, araddr = '0;
  logic [31:0]          wdata = '0, rdata, rng = 32'hb41c;
  logic [1:0]           bresp, rresp;
  logic [3:0]           wstrb = 4'hf;
  logic [7:0]           rl[8] = '{8'h64, 8'h68, 8'h6a, 8'h6b, 8'h80, 8'h81, 8'h65, 8'h82};
  logic [3:0]           evs[7] = '{4'b0100, 4'b0001, 4'b1100, 4'b1010, 4'b1001, 4'b0010, 4'b1011};
  ccs_pkg::ccs_engine_t engine = '0;
  ccs_pkg::ccs_ctrl_t   ctrl, exp_c;
  int                   num_errors = 0, checked = 0, cyc = 0, fg = 0, stp = 0;
  int                   mreg[256];
  always #50 clk = ~clk;
  ccs_top dut_u (.clk(clk), .rst_n(rst_n), .clk_en(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .engine(engine), .ctrl(ctrl),
    .trigger_input_pin(trig_pin), .status_output_pin(stat_pin));
  ccs_host_model host_u (.clk(clk), .rst_n(rst_n), .want_trig(want_trig), .status_output_pin(stat_pin),
    .trigger_input_pin(trig_pin), .status_seen_q(stat_seen));
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic mapped(input logic [7:0] i);
    return i inside {8'h64, 8'h68, 8'h6a, 8'h6b, 8'h80, 8'h81, 8'h82};
  endfunction
  function automatic logic [31:0] route_exp();
    logic       bg;
    logic       act;
    logic [1:0] park;
    bg = mreg[8'h80][1];
    park = bg ? 2'h3 : mreg[8'h64][1:0];
    act = !bg && !park[0];
    return {26'h0, act, 1'b0, act, park, mreg[8'h6b][0] ? want_trig : mreg[8'h81][0]};
  endfunction
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (!bvalid);
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
    `CHK(bresp, mapped(i) ? ccs_pkg::CCS_RESP_OKAY : ccs_pkg::CCS_RESP_SLVERR)
    if (mapped(i) && !(i inside {8'h6a, 8'h82}) && wstrb[0]) mreg[i] = d;
  endtask
  task automatic rd(input logic [7:0] i);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    `CHK(rdata, i == 8'h82 ? route_exp() : 32'(mreg[i]))
    `CHK(rresp, mapped(i) ? ccs_pkg::CCS_RESP_OKAY : ccs_pkg::CCS_RESP_SLVERR)
  endtask
  task automatic chk_ctrl();
    repeat (4) @(posedge clk);
    exp_c.bg_enable = mreg[8'h80][1];
    exp_c.parked_core = exp_c.bg_enable ? 2'h3 : mreg[8'h64][1:0];
    exp_c.stand_in_active = !exp_c.bg_enable && !mreg[8'h64][0];
    exp_c.stand_in_core = {1'b0, exp_c.stand_in_active};
    exp_c.offset_averaging_depth = mreg[8'h68][6:4];
    exp_c.linearity_averaging_depth = mreg[8'h68][2:0];
    exp_c.trigger = mreg[8'h6b][0] ? want_trig : mreg[8'h81][0];
    `CHK(ctrl, exp_c)
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    foreach (mreg[k]) mreg[k] = 0;
    mreg[8'h64] = 8'h02;
    mreg[8'h68] = 8'h61;
    mreg[8'h81] = 8'h01;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rl[k]) rd(rl[k]);
    chk_ctrl();
    wr(8'h6a, 8'hff);
    wr(8'h82, 8'h3f);
    wr(8'h65, 8'h5a);
    for (int k = 0; k < 8; k++) begin
      wr(8'h80, {6'h0, k[2], 1'b0});
      wr(8'h64, {6'h0, k[1:0]});
      wr(8'h68, 8'(xs()));
      chk_ctrl();
    end
    for (int s = 0; s < 2; s++) begin
      wr(8'h6b, {7'h0, s[0]});
      for (int k = 0; k < 4; k++) begin
        want_trig <= k[0];
        wr(8'h81, {7'h0, k[1]});
        chk_ctrl();
      end
    end
    foreach (evs[e]) begin
      wr(8'h80, {6'h0, evs[e][3], 1'b0});
      engine <= {evs[e][2:0], 4'(xs())};
      @(posedge clk);
      engine <= {3'b000, engine.code, engine.alarm};
      if (evs[e][2]) fg = 1;
      if (evs[e][3] ? evs[e][1] : evs[e][2]) stp = 1;
      else if (evs[e][0]) stp = 0;
      mreg[8'h6a] = {engine.code, stp[0], fg[0]};
      repeat (3) @(posedge clk);
      rd(8'h6a);
      for (int s = 0; s < 4; s++) begin
        wr(8'h6b, {5'h0, s[1:0], 1'b0});
        repeat (4) @(posedge clk);
        `CHK(stat_seen, s == 0 ? fg[0] : s == 1 ? stp[0] : s == 2 ? engine.alarm : 1'b0)
      end
    end
    wstrb <= 4'he;
    wr(8'h68, 8'h00);
    wstrb <= 4'hf;
    ce <= 1'b0;
    engine <= {3'b001, engine.code, engine.alarm};
    repeat (2) @(posedge clk);
    engine <= {3'b000, engine.code, engine.alarm};
    ce <= 1'b1;
    rd(8'h6a);
    foreach (rl[k]) rd(rl[k]);
    wrap_up();
  end
endmodule
